// >>> pkg/oab_pkg.sv
// shared types and constants of the operand address and branch unit
// assumes a byte-wide memory space with 16-bit addresses
package oab_pkg;

  // widths and reset values
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] DATA_RST = 8'h00;
  // high byte used by the first-page modes
  localparam logic [7:0] PAGE0_HI = 8'h00;
  // highest address of the byte offset indexed mode
  localparam logic [15:0] IDX_BYTE_TOP = 16'h01FE;
  // condition code bit positions in ccrIn
  localparam int CCR_C = 0;
  localparam int CCR_Z = 1;
  localparam int CCR_N = 2;
  localparam int CCR_I = 3;
  localparam int CCR_H = 4;
  // read data arrive this many cycles after the read strobe
  localparam int MEM_RD_LAT = 1;

  // instruction class of a request
  typedef enum logic [2:0] {
    clsRegMem, clsRmw, clsBranch, clsBranchSub,
    clsBitBranch, clsBitOp, clsJump
  } oab_class_t;

  // operand addressing mode
  typedef enum logic [2:0] {
    modeImm, modeDir, modeExt, modeIdxNone,
    modeIdxByte, modeIdxWord, modeInhA, modeInhX
  } oab_mode_t;

  // register/memory operations
  typedef enum logic [3:0] {
    rmAdd, rmAdc, rmAnd, rmBitTest, rmCmpA, rmCmpX, rmXor, rmLoadA,
    rmLoadX, rmMultiply, rmOr, rmSbc, rmStoreA, rmStoreX, rmSub
  } oab_rm_op_t;

  // read-modify-write operations
  typedef enum logic [3:0] {
    mdShl, mdAsr, mdShr, mdRol, mdRor, mdClear, mdCompl, mdNegate,
    mdInc, mdDec, mdTestNegZero, mdBitSet, mdBitClear
  } oab_md_op_t;

  // branch conditions
  typedef enum logic [3:0] {
    cdAlways, cdNever, cdHigher, cdLowerSame, cdCarryClr, cdCarrySet,
    cdNotEqual, cdEqual, cdHalfClr, cdHalfSet, cdPlus, cdMinus,
    cdMaskClr, cdMaskSet, cdIrqLow, cdIrqHigh
  } oab_cond_t;

endpackage

// >>> hw/oab_ea_calc.sv
// effective operand address of the memory addressing modes
// assumes the caller holds the instruction bytes stable while it looks
`timescale 1ns/1ps
module oab_ea_calc (
  input oab_pkg::oab_mode_t mode,
  input logic [7:0] byte1,
  input logic [7:0] byte2,
  input logic [7:0] idx,
  output logic [15:0] ea
);
  import oab_pkg::*;

  logic [8:0] sum9; // nine-bit sum of byte offset and index

  // address per mode, purely combinational
  always_comb
  begin
    sum9 = {1'b0, byte1} + {1'b0, idx};
    case (mode)
      modeDir:
        ea = {PAGE0_HI, byte1};
      modeExt:
        ea = {byte1, byte2};
      modeIdxNone:
        ea = {PAGE0_HI, idx};
      modeIdxByte:
        ea = {7'h00, sum9};
      modeIdxWord:
        ea = {byte1, byte2} + {8'h00, idx};
      default:
        ea = ADDR_RST; // immediate and inherent have no address
    endcase
  end

endmodule

// >>> hw/oab_alu.sv
// data path for register/memory and read-modify-write operations
// assumes operands are settled; result is combinational
`timescale 1ns/1ps
module oab_alu (
  input logic isRmw,
  input logic [3:0] op,
  input logic [7:0] regVal,
  input logic [7:0] memVal,
  input logic [2:0] bitSel,
  input logic carryIn,
  output logic [7:0] result,
  output logic [7:0] resultHi,
  output logic carry,
  output logic carryValid
);
  import oab_pkg::*;

  logic [8:0] s9; // sum or difference with carry out
  logic [15:0] prod; // multiplier product
  logic [7:0] mask; // one-hot bit select

  // operation select
  always_comb
  begin
    s9 = 9'h000;
    prod = regVal * memVal;
    mask = 8'h01 << bitSel;
    result = DATA_RST;
    resultHi = DATA_RST;
    carry = carryIn;
    carryValid = 1'b0;
    if (isRmw)
    begin
      // single operand in memVal
      case (oab_md_op_t'(op))
        mdShl:
        begin
          result = {memVal[6:0], 1'b0};
          carry = memVal[7];
          carryValid = 1'b1;
        end
        mdAsr, mdShr, mdRor:
        begin
          // all three shift bit 0 out into carry
          result = memVal >> 1;
          if (oab_md_op_t'(op) == mdAsr)
            result[7] = memVal[7];
          else if (oab_md_op_t'(op) == mdRor)
            result[7] = carryIn;
          carry = memVal[0];
          carryValid = 1'b1;
        end
        mdRol:
        begin
          result = {memVal[6:0], carryIn};
          carry = memVal[7];
          carryValid = 1'b1;
        end
        mdClear:
          result = 8'h00;
        mdCompl:
        begin
          result = ~memVal;
          carry = 1'b1;
          carryValid = 1'b1;
        end
        mdNegate:
        begin
          result = 8'h00 - memVal;
          carry = (memVal != 8'h00);
          carryValid = 1'b1;
        end
        mdInc:
          result = memVal + 8'h01;
        mdDec:
          result = memVal - 8'h01;
        mdBitSet:
          result = memVal | mask;
        mdBitClear:
          result = memVal & ~mask;
        default:
          result = memVal; // test passes value unchanged
      endcase
    end
    else
    begin
      // register operand in regVal, memory operand in memVal
      case (oab_rm_op_t'(op))
        rmAdd, rmAdc:
        begin
          s9 = {1'b0, regVal} + {1'b0, memVal};
          if (oab_rm_op_t'(op) == rmAdc)
            s9 = s9 + {8'h00, carryIn};
          result = s9[7:0];
          carry = s9[8];
          carryValid = 1'b1;
        end
        rmSub, rmSbc, rmCmpA, rmCmpX:
        begin
          s9 = {1'b0, regVal} - {1'b0, memVal};
          if (oab_rm_op_t'(op) == rmSbc)
            s9 = s9 - {8'h00, carryIn};
          result = s9[7:0];
          carry = s9[8]; // borrow
          carryValid = 1'b1;
        end
        rmAnd, rmBitTest:
          result = regVal & memVal;
        rmXor:
          result = regVal ^ memVal;
        rmOr:
          result = regVal | memVal;
        rmMultiply:
        begin
          result = prod[7:0];
          resultHi = prod[15:8];
          carry = 1'b0;
          carryValid = 1'b1;
        end
        rmStoreA, rmStoreX:
          result = regVal;
        default:
          result = memVal; // loads
      endcase
    end
  end

endmodule

// >>> hw/oab_unit.sv
// operand address, read-modify-write and branch sequencer of the cpu
// assumes a synchronous memory: data one cycle after the read strobe;
// opcode decode is outside and hands over class, mode and operation
`timescale 1ns/1ps

// Function
// - no-offset indexed address is index, page zero
// - byte-offset indexed adds byte and index, 9 bits
// - word-offset indexed adds index to 16-bit offset
// - first offset byte high, second byte low
// - taken branch adds offset, else next instruction
// - branch offset signed, -128 to +127
// - branches alone use relative addressing
// - read, modify, write back same place
// - negative-or-zero test never writes back
// - bit branch: opcode, direct address, offset
// - bit branch taken only when bit matches
// - tested bit always copied into carry
// - bit set/clear direct on first 256 bytes
// - register/memory: register operand and memory operand
// - register/memory group offers the listed operations
// - read-modify-write group offers the listed operations
// - branch conditions, always, never, subroutine
// - jumps use no register operand
// - direct address high byte is zero
// - extended address from two following bytes
module oab_unit (
  input logic ref_clk,
  input logic rst_n,
  input logic reqValid,
  input oab_pkg::oab_class_t reqClass,
  input oab_pkg::oab_mode_t reqMode,
  input logic [3:0] reqOp,
  input logic [2:0] reqBit,
  input logic reqBitSet,
  input logic [7:0] byte1,
  input logic [7:0] byte2,
  input logic [7:0] accReg,
  input logic [7:0] idxReg,
  input logic [15:0] pcNext,
  input logic [4:0] ccrIn,
  input logic irqLevel,
  input logic [7:0] memRdata,
  output logic [15:0] memAddr,
  output logic memRd,
  output logic memWr,
  output logic [7:0] memWdata,
  output logic busy,
  output logic done,
  output logic [15:0] pcOut,
  output logic branchTaken,
  output logic subCall,
  output logic carryOut,
  output logic carryLoad,
  output logic [7:0] accOut,
  output logic accLoad,
  output logic [7:0] idxOut,
  output logic idxLoad
);
  import oab_pkg::*;

  // sequencer states
  typedef enum logic [1:0] {stIdle, stRead, stExec, stWrite} oab_state_t;

  // whole state of the unit
  typedef struct packed {
    oab_state_t state;
    oab_class_t cls;
    oab_mode_t mode;
    logic [3:0] op;
    logic [2:0] bitSel;
    logic bitSet;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] acc;
    logic [7:0] idx;
    logic [15:0] pcNext;
    logic [4:0] ccr;
    logic [7:0] opnd; // operand not taken from memory
    logic fromMem; // operand comes from memRdata
    logic [15:0] memAddr;
    logic memRd;
    logic memWr;
    logic [7:0] memWdata;
    logic busy;
    logic done;
    logic [15:0] pcOut;
    logic taken;
    logic subCall;
    logic carry;
    logic carryLoad;
    logic [7:0] accOut;
    logic accLoad;
    logic [7:0] idxOut;
    logic idxLoad;
  } oab_regs_t;

  oab_regs_t r; // registered state
  oab_regs_t next_r; // next state
  logic [15:0] reqEa; // address of the incoming request
  logic [7:0] aluReg; // register operand to the data path
  logic [7:0] aluMem; // memory operand to the data path
  logic [7:0] aluRes; // data path result
  logic [7:0] aluHi; // product high byte
  logic aluCarry; // data path carry
  logic aluCarryValid; // data path changes carry
  logic tested; // bit under test

  // branch target: sign-extend, wrap at 16 bits
  function automatic logic [15:0] relTarget(
    input logic [15:0] pc,
    input logic [7:0] off
  );
    relTarget = pc + {{8{off[7]}}, off};
  endfunction

  // condition of a relative branch
  function automatic logic condTrue(
    input oab_cond_t cond,
    input logic [4:0] ccr,
    input logic irq
  );
    case (cond)
      cdAlways: condTrue = 1'b1;
      cdNever: condTrue = 1'b0;
      cdHigher: condTrue = !(ccr[CCR_C] | ccr[CCR_Z]);
      cdLowerSame: condTrue = ccr[CCR_C] | ccr[CCR_Z];
      cdCarryClr: condTrue = !ccr[CCR_C];
      cdCarrySet: condTrue = ccr[CCR_C];
      cdNotEqual: condTrue = !ccr[CCR_Z];
      cdEqual: condTrue = ccr[CCR_Z];
      cdHalfClr: condTrue = !ccr[CCR_H];
      cdHalfSet: condTrue = ccr[CCR_H];
      cdPlus: condTrue = !ccr[CCR_N];
      cdMinus: condTrue = ccr[CCR_N];
      cdMaskClr: condTrue = !ccr[CCR_I];
      cdMaskSet: condTrue = ccr[CCR_I];
      cdIrqLow: condTrue = !irq;
      default: condTrue = irq;
    endcase
  endfunction

  // address of the request as it arrives
  oab_ea_calc uEa (
    .mode(reqMode),
    .byte1(byte1),
    .byte2(byte2),
    .idx(idxReg),
    .ea(reqEa)
  );

  // operands from the latched request
  always_comb
  begin
    aluMem = r.fromMem ? memRdata : r.opnd;
    // compare-index, index load and index store use the index
    if (r.cls == clsRegMem && (r.op == 4'(rmCmpX) ||
        r.op == 4'(rmLoadX) || r.op == 4'(rmStoreX)))
      aluReg = r.idx;
    else
      aluReg = r.acc;
    tested = memRdata[r.bitSel];
  end

  oab_alu uAlu (
    .isRmw(r.cls != clsRegMem),
    .op(r.op),
    .regVal(aluReg),
    .memVal(aluMem),
    .bitSel(r.bitSel),
    .carryIn(r.ccr[CCR_C]),
    .result(aluRes),
    .resultHi(aluHi),
    .carry(aluCarry),
    .carryValid(aluCarryValid)
  );

  // next-state logic of the sequencer
  always_comb
  begin
    next_r = r;
    // strobes last one cycle
    next_r.memRd = 1'b0;
    next_r.memWr = 1'b0;
    next_r.done = 1'b0;
    next_r.carryLoad = 1'b0;
    next_r.accLoad = 1'b0;
    next_r.idxLoad = 1'b0;
    case (r.state)
      stIdle:
      begin
        // requests while busy are ignored; only idle takes one
        if (reqValid)
        begin
          next_r.cls = reqClass;
          next_r.mode = reqMode;
          next_r.op = reqOp;
          next_r.bitSel = reqBit;
          next_r.bitSet = reqBitSet;
          next_r.byte1 = byte1;
          next_r.byte2 = byte2;
          next_r.acc = accReg;
          next_r.idx = idxReg;
          next_r.pcNext = pcNext;
          next_r.ccr = ccrIn;
          next_r.fromMem = 1'b0;
          next_r.taken = 1'b0;
          next_r.subCall = 1'b0;
          next_r.pcOut = pcNext; // sequential flow by default
          next_r.memAddr = reqEa;
          case (reqClass)
            clsBranch, clsBranchSub:
            begin
              // no memory access, answer next cycle
              next_r.taken = (reqClass == clsBranchSub) ||
                condTrue(oab_cond_t'(reqOp), ccrIn, irqLevel);
              if (next_r.taken)
                next_r.pcOut = relTarget(pcNext, byte1);
              next_r.subCall = (reqClass == clsBranchSub);
              next_r.done = 1'b1;
            end
            clsJump:
            begin
              // target is the address itself, no register read
              next_r.pcOut = reqEa;
              next_r.subCall = reqOp[0];
              next_r.done = 1'b1;
            end
            clsBitBranch, clsBitOp:
            begin
              // direct address in the byte after the opcode
              next_r.memAddr = {PAGE0_HI, byte1};
              next_r.memRd = 1'b1;
              next_r.fromMem = 1'b1;
              next_r.op = reqBitSet ? 4'(mdBitSet) : 4'(mdBitClear);
              next_r.state = stRead;
            end
            clsRegMem:
            begin
              if (reqOp == 4'(rmStoreA) || reqOp == 4'(rmStoreX))
              begin
                // store: write only, no read
                next_r.memWr = 1'b1;
                next_r.memWdata =
                  (reqOp == 4'(rmStoreX)) ? idxReg : accReg;
                next_r.state = stWrite;
              end
              else if (reqOp == 4'(rmMultiply))
              begin
                next_r.opnd = idxReg; // multiplies the two registers
                next_r.state = stExec;
              end
              else if (reqMode == modeImm)
              begin
                next_r.opnd = byte1;
                next_r.state = stExec;
              end
              else
              begin
                next_r.memRd = 1'b1;
                next_r.fromMem = 1'b1;
                next_r.state = stRead;
              end
            end
            default:
            begin
              // read-modify-write on a register or on memory
              if (reqMode == modeInhA || reqMode == modeInhX)
              begin
                next_r.opnd = (reqMode == modeInhA) ? accReg : idxReg;
                next_r.state = stExec;
              end
              else
              begin
                next_r.memRd = 1'b1;
                next_r.fromMem = 1'b1;
                next_r.state = stRead;
              end
            end
          endcase
        end
      end
      stRead:
        next_r.state = stExec; // read data due next cycle
      stExec:
      begin
        next_r.state = stIdle;
        next_r.done = 1'b1;
        if (r.cls == clsBitBranch)
        begin
          next_r.carry = tested;
          next_r.carryLoad = 1'b1;
          next_r.taken = (tested == r.bitSet);
          if (tested == r.bitSet)
            next_r.pcOut = relTarget(r.pcNext, r.byte2);
        end
        else
        begin
          next_r.carry = aluCarry;
          next_r.carryLoad = aluCarryValid;
          if (r.cls == clsRegMem)
          begin
            // compares and bit test only affect flags
            case (oab_rm_op_t'(r.op))
              rmLoadX:
              begin
                next_r.idxOut = aluRes;
                next_r.idxLoad = 1'b1;
              end
              rmMultiply:
              begin
                next_r.accOut = aluRes;
                next_r.accLoad = 1'b1;
                next_r.idxOut = aluHi;
                next_r.idxLoad = 1'b1;
              end
              rmBitTest, rmCmpA, rmCmpX: ;
              default:
              begin
                next_r.accOut = aluRes;
                next_r.accLoad = 1'b1;
              end
            endcase
          end
          else if (r.op == 4'(mdTestNegZero))
            ;
          else if (r.mode == modeInhA && r.cls == clsRmw)
          begin
            next_r.accOut = aluRes;
            next_r.accLoad = 1'b1;
          end
          else if (r.mode == modeInhX && r.cls == clsRmw)
          begin
            next_r.idxOut = aluRes;
            next_r.idxLoad = 1'b1;
          end
          else
          begin
            // write back to the address just read, done after it
            next_r.memWr = 1'b1;
            next_r.memWdata = aluRes;
            next_r.done = 1'b0;
            next_r.state = stWrite;
          end
        end
      end
      default:
      begin
        next_r.state = stIdle; // write strobe just went out
        next_r.done = 1'b1;
      end
    endcase
    next_r.busy = (next_r.state != stIdle);
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  // every output straight from the state register
  assign memAddr = r.memAddr;
  assign memRd = r.memRd;
  assign memWr = r.memWr;
  assign memWdata = r.memWdata;
  assign busy = r.busy;
  assign done = r.done;
  assign pcOut = r.pcOut;
  assign branchTaken = r.taken;
  assign subCall = r.subCall;
  assign carryOut = r.carry;
  assign carryLoad = r.carryLoad;
  assign accOut = r.accOut;
  assign accLoad = r.accLoad;
  assign idxOut = r.idxOut;
  assign idxLoad = r.idxLoad;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  idx_page0_a: assert property (memRd && r.mode == modeIdxNone &&
    r.cls inside {clsRegMem, clsRmw} |-> memAddr == {8'h00, r.idx})
    else $error("no-offset indexed address off page zero");
  idx_byte_a: assert property (memRd && r.mode == modeIdxByte &&
    r.cls inside {clsRegMem, clsRmw} |-> memAddr <= IDX_BYTE_TOP &&
    memAddr == {8'h00, r.byte1} + {8'h00, r.idx})
    else $error("byte-offset indexed address wrong");
  idx_word_a: assert property (memRd && r.mode == modeIdxWord &&
    r.cls inside {clsRegMem, clsRmw} |->
    memAddr == {r.byte1, r.byte2} + {8'h00, r.idx})
    else $error("word-offset indexed address wrong");
  branch_target_a: assert property (reqValid && !busy &&
    reqClass == clsBranch |=> done && (branchTaken ? pcOut ==
    r.pcNext + {{8{r.byte1[7]}}, r.byte1} : pcOut == r.pcNext))
    else $error("branch answer or target wrong");
  rmw_same_a: assert property (memRd && r.cls == clsRmw &&
    r.op != 4'(mdTestNegZero) |-> ##2 memWr && memAddr ==
    $past(memAddr, 2) ##1 done)
    else $error("write-back not to the address read");
  test_nowrite_a: assert property (r.state == stExec &&
    r.cls == clsRmw && r.op == 4'(mdTestNegZero) |=> !memWr && done)
    else $error("test operation wrote back");
  bit_carry_a: assert property (reqValid && !busy &&
    reqClass == clsBitBranch |-> ##3 done && carryLoad &&
    branchTaken == (carryOut == r.bitSet))
    else $error("tested bit not in carry or wrong branch");
  direct_page0_a: assert property ((memRd || memWr) &&
    (r.mode == modeDir || r.cls inside {clsBitOp, clsBitBranch})
    |-> memAddr[15:8] == 8'h00)
    else $error("direct access off page zero");
  jump_noreg_a: assert property (done && r.cls == clsJump |->
    !accLoad && !idxLoad && !carryLoad)
    else $error("jump touched a register");
  // branchTaken is a held level, so judge it only in the done cycle
  rel_only_a: assert property (done && branchTaken |->
    r.cls inside {clsBranch, clsBranchSub, clsBitBranch})
    else $error("non-branch took a relative target");
  load_mem_a: assert property (accLoad && r.cls == clsRegMem &&
    r.op == 4'(rmLoadA) && r.fromMem |-> accOut == $past(memRdata))
    else $error("load did not take memory operand");

  taken_branch_c: cover property (done && branchTaken &&
    r.cls == clsBranch);
  rmw_mem_c: cover property (memRd && r.cls == clsRmw ##2 memWr);
  bit_branch_c: cover property (done && r.cls == clsBitBranch &&
    branchTaken);
  multiply_c: cover property (idxLoad && accLoad);

endmodule

// >>> tb/oab_mem_model.sv
// memory model on the far side of the unit: byte array, 1-cycle reads
// assumes the unit's strobes are registered and last one cycle
`timescale 1ns/1ps
module oab_mem_model (
  input wire logic ref_clk,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata
);
  // contents seeded from the address so neighbours differ
  logic [7:0] mem [0:65535];
  initial
  begin
    memRdata = 8'h00;
    for (int i = 0; i < 65536; i++)
      mem[i] = i[7:0] ^ 8'hA5;
  end
  // data one cycle after the strobe; otherwise toggle, so a late
  // sample never finds stale data that happens to match
  always @(posedge ref_clk)
  begin
    if (memRd)
      memRdata <= mem[memAddr];
    else
      memRdata <= ~memRdata;
    if (memWr)
      mem[memAddr] <= memWdata;
  end
endmodule

// >>> tb/cpu_operand_address_branch_unit_tb_top.sv
// self-checking bench of the operand address and branch unit
// assumes the memory model answers one cycle after each read strobe
`timescale 1ns/1ps
module cpu_operand_address_branch_unit_tb_top;
  import oab_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0;
  oab_class_t reqClass = clsRegMem;
  oab_mode_t reqMode = modeImm;
  logic [3:0] reqOp = 4'h0;
  logic [2:0] reqBit = 3'h0;
  logic reqBitSet = 1'b0, irqLevel = 1'b0;
  logic [7:0] byte1 = 8'h00, byte2 = 8'h00, accReg = 8'h00;
  logic [7:0] idxReg = 8'hFF, memRdata, memWdata, accOut, idxOut;
  logic [15:0] pcNext = 16'h0000, memAddr, pcOut;
  logic [4:0] ccrIn = 5'h01;
  logic memRd, memWr, busy, done, branchTaken, subCall;
  logic carryOut, carryLoad, accLoad, idxLoad;
  int err_total = 0, num_checks = 0, wrCnt = 0;
  always #20 ref_clk = ~ref_clk;
  // write strobes counted to prove the test op leaves memory alone
  always @(posedge ref_clk)
    if (memWr === 1'b1)
      wrCnt++;
  oab_unit dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reqValid(reqValid),
    .reqClass(reqClass), .reqMode(reqMode), .reqOp(reqOp),
    .reqBit(reqBit), .reqBitSet(reqBitSet), .byte1(byte1),
    .byte2(byte2), .accReg(accReg), .idxReg(idxReg), .pcNext(pcNext),
    .ccrIn(ccrIn), .irqLevel(irqLevel), .memRdata(memRdata),
    .memAddr(memAddr), .memRd(memRd), .memWr(memWr),
    .memWdata(memWdata), .busy(busy), .done(done), .pcOut(pcOut),
    .branchTaken(branchTaken), .subCall(subCall), .carryOut(carryOut),
    .carryLoad(carryLoad), .accOut(accOut), .accLoad(accLoad),
    .idxOut(idxOut), .idxLoad(idxLoad));
  oab_mem_model mem_u (.ref_clk(ref_clk), .memRd(memRd), .memWr(memWr),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));
  // one comparison, widened to 16 bits
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one request; returns in the done cycle, bounded wait
  task automatic run(input oab_class_t c, input oab_mode_t m,
    input logic [3:0] op, input logic [7:0] b1, input logic [7:0] b2);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    reqValid = 1'b1;
    reqClass = c;
    reqMode = m;
    reqOp = op;
    byte1 = b1;
    byte2 = b2;
    @(posedge ref_clk);
    #1;
    reqValid = 1'b0;
    while (done !== 1'b1 && n < 10)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk({done, busy}, 2'b10);
  endtask
  // address of each memory mode through the test op, no write-back
  task automatic am(input oab_mode_t m, input logic [7:0] b1,
    input logic [7:0] b2, input logic [15:0] e);
    int w;
    w = wrCnt;
    run(clsRmw, m, mdTestNegZero, b1, b2);
    chk(memAddr, e);
    chk(wrCnt - w, 0);
  endtask
  // relative branch from a pc near the top, so carry must drop
  task automatic br(input oab_cond_t c, input logic [7:0] off,
    input logic tk);
    pcNext = 16'hFFF0;
    run(clsBranch, modeImm, c, off, 8'h00);
    chk(branchTaken, tk);
    chk(pcOut, tk ? 16'hFFF0 + {{8{off[7]}}, off} : 16'hFFF0);
  endtask
  // bit test and branch on page-zero byte 0x33, which holds 0x96
  task automatic bb(input logic [2:0] b, input logic s, input logic tk,
    input logic cy);
    reqBit = b;
    reqBitSet = s;
    pcNext = 16'h0200;
    run(clsBitBranch, modeDir, 4'h0, 8'h33, 8'hF0);
    chk(memAddr, 16'h0033);
    chk({carryLoad, carryOut}, {1'b1, cy});
    chk(pcOut, tk ? 16'h01F0 : 16'h0200);
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog, far beyond the hundred or so cycles the tests need
  initial
  begin
    #100000;
    err_total++;
    wrap_up;
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    am(modeIdxNone, 8'h00, 8'h00, 16'h00FF);
    am(modeIdxByte, 8'hFF, 8'h00, 16'h01FE);
    am(modeIdxWord, 8'h12, 8'h34, 16'h1333);
    am(modeDir, 8'h5A, 8'h00, 16'h005A);
    am(modeExt, 8'h12, 8'h34, 16'h1234);
    run(clsRmw, modeIdxByte, mdInc, 8'h40, 8'h00);
    chk(mem_u.mem[16'h013F], (8'h3F ^ 8'hA5) + 8'h01);
    accReg = 8'hFF;
    run(clsRmw, modeInhA, mdInc, 8'h00, 8'h00);
    chk({accLoad, accOut}, 9'h100);
    br(cdAlways, 8'h7F, 1'b1);
    br(cdAlways, 8'h80, 1'b1);
    br(cdNever, 8'h10, 1'b0);
    br(cdCarrySet, 8'h05, 1'b1);
    br(cdCarryClr, 8'h05, 1'b0);
    br(cdIrqLow, 8'h05, 1'b1);
    br(cdIrqHigh, 8'h05, 1'b0);
    bb(3'h1, 1'b1, 1'b1, 1'b1);
    bb(3'h1, 1'b0, 1'b0, 1'b1);
    bb(3'h0, 1'b0, 1'b1, 1'b0);
    bb(3'h0, 1'b1, 1'b0, 1'b0);
    reqBit = 3'h0;
    reqBitSet = 1'b1;
    run(clsBitOp, modeDir, 4'h0, 8'h33, 8'h00);
    chk(mem_u.mem[16'h0033], 8'h97);
    reqBit = 3'h7;
    reqBitSet = 1'b0;
    run(clsBitOp, modeDir, 4'h0, 8'h33, 8'h00);
    chk(mem_u.mem[16'h0033], 8'h17);
    run(clsRegMem, modeDir, rmLoadA, 8'h5A, 8'h00);
    chk({accLoad, accOut}, 9'h1FF);
    accReg = 8'h3C;
    run(clsRegMem, modeDir, rmStoreA, 8'h70, 8'h00);
    chk(mem_u.mem[16'h0070], 8'h3C);
    run(clsRegMem, modeImm, rmMultiply, 8'h00, 8'h00);
    chk({idxOut, accOut}, 16'h3BC4);
    chk({idxLoad, accLoad, carryLoad, carryOut}, 4'hE);
    run(clsRegMem, modeImm, rmAdd, 8'hD0, 8'h00);
    chk({carryLoad, carryOut, accOut}, 10'h30C);
    run(clsRegMem, modeDir, rmCmpX, 8'h5A, 8'h00);
    chk({accLoad, idxLoad, carryLoad, carryOut}, 4'h2);
    run(clsJump, modeExt, 4'h1, 8'h12, 8'h34);
    chk({subCall, pcOut}, 17'h11234);
    wrap_up;
  end
endmodule
